// [design/wake_watchdog_consts.svh]
// constants for the wake-up and watchdog control block
`ifndef WAKE_WATCHDOG_CONSTS_SVH
`define WAKE_WATCHDOG_CONSTS_SVH
`define ADDR_SELECT      4'h0
`define ADDR_FLAGS       4'h1
`define ADDR_IRQ_STATUS  4'h2
`define ADDR_IRQ_MASK    4'h3
`define SELECT_RESET     8'h80
`define SELECT_WMASK     8'h7F
`define SEL_PRESCALE_LSB 0
`define SEL_PRESCALE_MSB 2
`define SEL_PULLUP_BIT   3
`define WAKE_DELAY_CYC   11'd1024
`define IRQ_EXTRA_CYC    11'd1
`define INSTR_DIV_LAST   2'd3
`define IRQ_BIT_WDT      0
`define IRQ_BIT_WAKE     1
`define IRQ_BIT_ONE      4'h1
`endif

// [design/wake_watchdog_pkg.sv]
// types for the wake-up and watchdog control block
package wake_watchdog_pkg;
  typedef enum logic [1:0] {
    ST_RUN   = 2'b00,
    ST_SLEEP = 2'b01,
    ST_DELAY = 2'b10,
    ST_IRQ   = 2'b11
  } pwr_state_e;
  typedef enum logic [1:0] {
    WK_NONE  = 2'b00,
    WK_PIN   = 2'b01,
    WK_IRQ   = 2'b10,
    WK_WDT   = 2'b11
  } wake_src_e;
endpackage

// [design/wake_and_watchdog_control.sv]
// power-down wake-up sequencing and watchdog timer
//
// The strobed register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`include "wake_watchdog_consts.svh"

// Functional notes
// R01: wake on reset, pin, interrupt, watchdog overflow
// R02: reset wake full reset; watchdog wake watchdog reset
// R03: powerdown flag cleared by clear, set by halt
// R04: time-out sets flag; resets only pc/sp
// R05: per-pin falling-edge wake, resume after halt
// R06: disabled or stack full: resume, keep pending
// R07: enabled and stack free: normal interrupt response
// R08: flag set before halt blocks its wake
// R09: 1024 clock delay before resuming
// R10: interrupt entry one more cycle later
// R11: watchdog clock RC or system clock/4
// R12: watchdog disabled: its instructions are no-ops
// R13: fixed eight-stage divide by 256
// R14: three-bit prescaler select 1:1 to 1:128
// R15: instruction clock source stops in power-down
// R16: RC oscillator keeps running in power-down
// R17: bit 3 enables usb pin pull-up
// R18: halt stops oscillator, sets pd, clears to
// R19: clear-watchdog resets divider and prescaler
module wake_and_watchdog_control
  import wake_watchdog_pkg::*;
#(
  parameter int NUM_PINS = 8,
  parameter int NUM_IRQ  = 4
) (
  input  wire logic                i_mclk,          // system clock, 50 MHz
  input  wire logic                i_rst,           // async reset, active high
  input  wire logic                i_ext_reset,     // external reset pin event
  input  wire logic                i_cfg_wdt_en,    // option: watchdog enabled
  input  wire logic                i_cfg_rc_src,    // option: 1 rc osc, 0 instr clock
  input  wire logic                i_cfg_rc_en,     // option: rc oscillator enabled
  input  wire logic                i_rc_tick,       // one-cycle rc oscillator tick
  input  wire logic [NUM_PINS-1:0] i_port_pins,     // i/o port pin levels
  input  wire logic [NUM_PINS-1:0] i_pin_wake_en,   // per-pin wake options
  input  wire logic [NUM_IRQ-1:0]  i_irq_req,       // interrupt request flags
  input  wire logic [NUM_IRQ-1:0]  i_irq_en,        // interrupt enables
  input  wire logic                i_stack_full,    // call stack full
  input  wire logic                i_halt_exec,     // halt instruction pulse
  input  wire logic                i_clrwdt_exec,   // clear-watchdog pulse
  input  wire logic                i_power_up,      // power-up pulse
  input  wire logic [3:0]          i_addr,          // register address
  input  wire logic [7:0]          i_wdata,         // register write data
  input  wire logic                i_wr,            // write strobe
  input  wire logic                i_rd,            // read strobe
  output logic      [7:0]          o_rdata,         // read data, next cycle
  output logic                     o_sys_clk_en,    // system oscillator running
  output logic                     o_cpu_run,       // cpu may execute
  output logic                     o_full_reset,    // full system reset pulse
  output logic                     o_wdt_reset,     // watchdog reset pulse
  output logic                     o_irq_service,   // take interrupt pulse
  output logic                     o_usb_pullup_en, // pull-up on usb pins
  output logic                     o_timeout_flag,  // time-out flag
  output logic                     o_powerdown_flag,// power-down flag
  output logic                     o_irq            // level interrupt
);

  ////////////////////////////////////////////////////////////////////////
  // state
  pwr_state_e          state_q;
  pwr_state_e          state_d;
  wake_src_e           src_q;
  wake_src_e           src_d;
  logic [10:0]         dly_q;
  logic [10:0]         dly_d;
  logic [7:0]          select_q;
  logic                timeout_flag_q;
  logic                powerdown_flag_q;
  logic [7:0]          base_div_q;
  logic [7:0]          prescale_q;
  logic [1:0]          instr_div_q;
  logic [NUM_PINS-1:0] pins_q;
  logic [NUM_IRQ-1:0]  irq_block_q;
  logic [1:0]          irq_stat_q;
  logic [1:0]          irq_mask_q;
  logic [7:0]          rdata_q;
  logic                full_rst_q;
  logic                wdt_rst_q;
  logic                irq_svc_q;

  ////////////////////////////////////////////////////////////////////////
  // wake decode
  wire sleeping   = (state_q == ST_SLEEP);
  wire [NUM_PINS-1:0] pin_fall;                                   // per-pin edges, below
  wire pin_wake   = |pin_fall;
  wire [NUM_IRQ-1:0] irq_wakes = i_irq_req & ~irq_block_q;       // R08
  wire irq_wake   = |irq_wakes;
  wire irq_taken  = |(irq_wakes & i_irq_en) & ~i_stack_full;    // R06 R07
  wire halt_ok    = i_halt_exec & (state_q == ST_RUN);
  wire clr_ok     = i_clrwdt_exec & i_cfg_wdt_en;                 // R12

  // per-pin falling-edge detect; flops start high, matching idle pins
  generate
    for (genvar gp = 0; gp < NUM_PINS; gp++) begin : g_pin
      always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
          pins_q[gp] <= 1'b1;
        end else begin
          pins_q[gp] <= i_port_pins[gp];
        end
      end
      assign pin_fall[gp] = pins_q[gp] & ~i_port_pins[gp] & i_pin_wake_en[gp]; // R05
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // watchdog clock select and divider chain
  wire instr_tick = (instr_div_q == `INSTR_DIV_LAST) & ~sleeping; // R11 R15
  wire rc_tick    = i_rc_tick & i_cfg_rc_en;                      // R16
  wire wdt_tick   = i_cfg_wdt_en & (i_cfg_rc_src ? rc_tick : instr_tick); // R11
  wire base_carry = wdt_tick & (&base_div_q);                     // R13
  wire [2:0] psel = select_q[`SEL_PRESCALE_MSB:`SEL_PRESCALE_LSB];
  // mask holds psel low ones, so overflow comes every 2**psel carries
  // an empty mask at psel zero makes every base carry an overflow
  wire [7:0] pmask = 8'hFF >> (4'd8 - {1'b0, psel});
  wire pre_hit    = ((prescale_q & pmask) == pmask);
  wire wdt_ovf    = base_carry & pre_hit;                         // R14
  wire wdt_clear  = clr_ok | halt_ok | wdt_ovf;                   // R19 R18

  // instruction clock divide by four, stopped while asleep
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      instr_div_q <= 2'h0;
    end else if (!sleeping) begin
      instr_div_q <= instr_div_q + 2'h1;
    end
  end

  // fixed eight-stage divider and prescaler
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      base_div_q <= 8'h00;
      prescale_q <= 8'h00;
    end else if (wdt_clear) begin
      base_div_q <= 8'h00;                                        // R19
      prescale_q <= 8'h00;
    end else if (wdt_tick) begin
      base_div_q <= base_div_q + 8'h01;                           // R13
      if (base_carry) begin
        prescale_q <= prescale_q + 8'h01;                         // R14
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // power state machine
  always_comb begin
    state_d = state_q;
    src_d   = src_q;
    dly_d   = dly_q;
    case (state_q)
      ST_RUN: begin
        // halt stops the oscillator and clears the watchdog
        if (halt_ok) begin
          state_d = ST_SLEEP;                                     // R18
          src_d   = WK_NONE;
        end
      end
      ST_SLEEP: begin
        dly_d = `WAKE_DELAY_CYC;
        // wake priority: watchdog, interrupt, then pin edge
        if (wdt_ovf) begin                                        // R01
          state_d = ST_DELAY;
          src_d   = WK_WDT;
        end else if (irq_wake) begin
          state_d = ST_DELAY;
          // disabled source or full stack resumes like a pin wake
          src_d   = irq_taken ? WK_IRQ : WK_PIN;
        end else if (pin_wake) begin
          state_d = ST_DELAY;
          src_d   = WK_PIN;
        end
      end
      ST_DELAY: begin
        dly_d = dly_q - 11'd1;                                    // R09
        // last delay cycle; interrupt wake gets one extra cycle
        if (dly_q == 11'd1) begin
          state_d = (src_q == WK_IRQ) ? ST_IRQ : ST_RUN;
          dly_d   = `IRQ_EXTRA_CYC;
        end
      end
      ST_IRQ: begin
        // one cycle beyond the restart delay before service
        state_d = ST_RUN;                                         // R10
      end
      default: begin
        state_d = ST_RUN;
      end
    endcase
  end

  // state registers; external reset overrides everything
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      state_q <= ST_RUN;
      src_q   <= WK_NONE;
      dly_q   <= 11'h000;
    // an external reset wakes from any state at once
    end else if (i_ext_reset) begin
      state_q <= ST_RUN;                                          // R02
      src_q   <= WK_NONE;
      dly_q   <= 11'h000;
    end else begin
      state_q <= state_d;
      src_q   <= src_d;
      dly_q   <= dly_d;
    end
  end

  // reset and service pulses at the end of the delay
  wire delay_done    = (state_q == ST_DELAY) & (dly_q == 11'd1) & ~i_ext_reset;
  wire wdt_wake_done = delay_done & (src_q == WK_WDT);
  wire irq_entry     = (state_q == ST_IRQ);

  // full reset follows the external reset pin by one cycle
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      full_rst_q <= 1'b0;
    end else begin
      full_rst_q <= i_ext_reset;                                  // R02
    end
  end

  // watchdog reset coincides with the restart of execution
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      wdt_rst_q <= 1'b0;
    end else begin
      wdt_rst_q <= wdt_wake_done;                                 // R04
    end
  end

  // service pulse as the extra interrupt cycle ends
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      irq_svc_q <= 1'b0;
    end else begin
      irq_svc_q <= irq_entry;                                     // R07 R10
    end
  end

  // interrupt flags already pending at halt cannot wake
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      irq_block_q <= '0;
    end else if (halt_ok) begin
      irq_block_q <= i_irq_req;                                   // R08
    end else if (!sleeping) begin
      irq_block_q <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // status flags
  // an overflow in the halt cycle is swallowed by the halt clear
  wire wdt_timeout = wdt_ovf & ~halt_ok;
  wire to_clear    = halt_ok | clr_ok | i_power_up;
  wire pd_clear    = clr_ok | i_power_up;

  // time-out flag, a new overflow wins over any clear except halt
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      timeout_flag_q <= 1'b0;
    end else if (wdt_timeout) begin
      timeout_flag_q <= 1'b1;                                     // R04
    end else if (to_clear) begin
      timeout_flag_q <= 1'b0;                                     // R18
    end
  end

  // power-down flag, set by halt, cleared by clear or power-up
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      powerdown_flag_q <= 1'b0;
    end else if (halt_ok) begin
      powerdown_flag_q <= 1'b1;                                   // R03
    end else if (pd_clear) begin
      powerdown_flag_q <= 1'b0;                                   // R03
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register file
  wire wr_select = i_wr & (i_addr == `ADDR_SELECT);
  wire wr_status = i_wr & (i_addr == `ADDR_IRQ_STATUS);
  wire wr_mask   = i_wr & (i_addr == `ADDR_IRQ_MASK);
  wire [1:0] irq_events = {state_q == ST_DELAY && dly_q == `WAKE_DELAY_CYC, wdt_timeout};
  wire [7:0] flags_rd = {4'h0, 2'(src_q), powerdown_flag_q, timeout_flag_q};
  // read address decode; unmapped addresses read zero
  wire hit_select = (i_addr == `ADDR_SELECT);
  wire hit_flags  = (i_addr == `ADDR_FLAGS);
  wire hit_status = (i_addr == `ADDR_IRQ_STATUS);
  wire hit_mask   = (i_addr == `ADDR_IRQ_MASK);
  wire [7:0] rd_mux =
    hit_select ? select_q :
    hit_flags  ? flags_rd :
    hit_status ? {6'h00, irq_stat_q} :
    hit_mask   ? {6'h00, irq_mask_q} : 8'h00;

  // select register: bit 7 reads one, pull-up default off
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      select_q <= `SELECT_RESET;
    end else if (wr_select) begin
      select_q <= (i_wdata & `SELECT_WMASK) | `SELECT_RESET;      // R14 R17
    end
  end

  // sticky status, set wins over write-one clear
  wire [1:0] stat_clr = {2{wr_status}} & i_wdata[1:0];
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      irq_stat_q <= 2'h0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~stat_clr) | irq_events;
    end
  end

  // interrupt mask, same layout as the status
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      irq_mask_q <= 2'h0;
    end else if (wr_mask) begin
      irq_mask_q <= i_wdata[1:0];
    end
  end

  // read data one cycle after the strobe
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= i_rd ? rd_mux : 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs
  assign o_rdata          = rdata_q;
  assign o_sys_clk_en     = ~sleeping;                            // R18
  assign o_cpu_run        = (state_q == ST_RUN);                  // R09
  assign o_full_reset     = full_rst_q;
  assign o_wdt_reset      = wdt_rst_q;
  assign o_irq_service    = irq_svc_q;
  assign o_usb_pullup_en  = select_q[`SEL_PULLUP_BIT];            // R17
  assign o_timeout_flag   = timeout_flag_q;
  assign o_powerdown_flag = powerdown_flag_q;
  assign o_irq            = |(irq_stat_q & irq_mask_q);

endmodule

// [bench/wake_watchdog_monitor.sv]
// assertion checker for the wake-up and watchdog block
`timescale 1ns/1ps
`include "wake_watchdog_consts.svh"
module wake_watchdog_monitor #(
  parameter int NUM_PINS = 8,
  parameter int NUM_IRQ  = 4
) (
  input wire logic       i_mclk,
  input wire logic       i_rst,
  input wire logic       i_ext_reset,
  input wire logic       i_cfg_wdt_en,
  input wire logic       i_halt_exec,
  input wire logic       i_clrwdt_exec,
  input wire logic       i_power_up,
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic       i_wr,
  input wire logic       i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic       o_sys_clk_en,
  input wire logic       o_cpu_run,
  input wire logic       o_full_reset,
  input wire logic       o_wdt_reset,
  input wire logic       o_irq_service,
  input wire logic       o_usb_pullup_en,
  input wire logic       o_timeout_flag,
  input wire logic       o_powerdown_flag
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  ////////////////////////////////////////////////////////////
  // cycles spent in the restart delay
  logic [10:0] dly_q;
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst || o_cpu_run || !o_sys_clk_en) dly_q <= 11'h000;
    else if (dly_q != 11'h7FF) dly_q <= dly_q + 11'h001;
  end
  ////////////////////////////////////////////////////////////
  a_halt_sleep: assert property (i_halt_exec && o_cpu_run && !i_ext_reset && !i_power_up |=>
    o_powerdown_flag && !o_timeout_flag && !o_sys_clk_en) else $error("halt did not enter sleep");
  a_sleep_no_run: assert property (!o_sys_clk_en |-> !o_cpu_run) else $error("cpu runs asleep");
  a_clr_pd: assert property (i_clrwdt_exec && i_cfg_wdt_en && !i_halt_exec |=>
    !o_powerdown_flag) else $error("clear left power-down flag");
  a_clr_noop: assert property (i_clrwdt_exec && !i_cfg_wdt_en && o_powerdown_flag && !i_power_up
    && !i_ext_reset && !i_halt_exec |=> o_powerdown_flag) else $error("disabled clear acted");
  a_powerup_pd: assert property (i_power_up && !i_halt_exec |=> !o_powerdown_flag)
    else $error("power-up left flag");
  a_ext_full: assert property (i_ext_reset |=> o_full_reset) else $error("no full reset");
  a_wake_delay: assert property ($rose(o_cpu_run) && !$past(i_ext_reset) |-> dly_q >= 11'h3FF)
    else $error("restart delay short");
  a_service_run: assert property (o_irq_service |-> o_cpu_run && !$past(o_cpu_run))
    else $error("service timing wrong");
  a_wdt_sets_to: assert property (o_wdt_reset |-> o_timeout_flag) else $error("time-out flag clear");
  a_pullup_wr: assert property (i_wr && i_addr == `ADDR_SELECT |=> o_usb_pullup_en == $past(i_wdata[3]))
    else $error("pull-up mismatch");
  a_unmapped_rd: assert property (i_rd && i_addr > `ADDR_IRQ_MASK |=> o_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_select_bit7: assert property (i_rd && i_addr == `ADDR_SELECT |=> o_rdata[7]) else $error("bit 7 low");
endmodule
bind wake_and_watchdog_control wake_watchdog_monitor #(.NUM_PINS(NUM_PINS), .NUM_IRQ(NUM_IRQ)) i_mon (
  .i_mclk(i_mclk), .i_rst(i_rst), .i_ext_reset(i_ext_reset), .i_cfg_wdt_en(i_cfg_wdt_en),
  .i_halt_exec(i_halt_exec), .i_clrwdt_exec(i_clrwdt_exec), .i_power_up(i_power_up), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_sys_clk_en(o_sys_clk_en),
  .o_cpu_run(o_cpu_run), .o_full_reset(o_full_reset), .o_wdt_reset(o_wdt_reset),
  .o_irq_service(o_irq_service), .o_usb_pullup_en(o_usb_pullup_en), .o_timeout_flag(o_timeout_flag),
  .o_powerdown_flag(o_powerdown_flag));

// [bench/tb_top.sv]
// self-checking bench for the wake-up and watchdog block
`timescale 1ns/1ps
`include "wake_watchdog_consts.svh"
module tb_top;
  logic       i_mclk, i_rst, i_cfg_wdt_en, i_cfg_rc_src, i_rc_tick, i_stack_full, i_wr, i_rd, tick_on;
  logic [7:0] i_port_pins, i_wdata;
  logic [3:0] i_irq_req, i_irq_en, i_addr, pul;
  wire  [7:0] o_rdata;
  wire        o_sys_clk_en, o_cpu_run, o_full_reset, o_wdt_reset, o_irq_service, o_usb_pullup_en;
  wire        o_timeout_flag, o_powerdown_flag, o_irq;
  int         n_fail, num_checks, n_cyc, n_wdt, n_srv, n_full;
  wake_and_watchdog_control i_dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_ext_reset(pul[3]),
    .i_cfg_wdt_en(i_cfg_wdt_en), .i_cfg_rc_src(i_cfg_rc_src), .i_cfg_rc_en(1'b1), .i_rc_tick(i_rc_tick),
    .i_port_pins(i_port_pins), .i_pin_wake_en(8'hFF), .i_irq_req(i_irq_req), .i_irq_en(i_irq_en),
    .i_stack_full(i_stack_full), .i_halt_exec(pul[0]), .i_clrwdt_exec(pul[1]), .i_power_up(pul[2]),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_sys_clk_en(o_sys_clk_en), .o_cpu_run(o_cpu_run), .o_full_reset(o_full_reset),
    .o_wdt_reset(o_wdt_reset), .o_irq_service(o_irq_service), .o_usb_pullup_en(o_usb_pullup_en),
    .o_timeout_flag(o_timeout_flag), .o_powerdown_flag(o_powerdown_flag), .o_irq(o_irq));
  ////////////////////////////////////////////////////////////
  // clock, rc tick every other cycle, pulse counters
  initial begin
    i_mclk = 1'b0;
    forever #10 i_mclk = ~i_mclk;
  end
  always @(posedge i_mclk) begin
    i_rc_tick <= tick_on && !i_rc_tick;
    if (o_wdt_reset === 1'b1) n_wdt++;
    if (o_irq_service === 1'b1) n_srv++;
    if (o_full_reset === 1'b1) n_full++;
  end
  ////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(string nm, logic [7:0] exp, logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(logic [3:0] a, logic [7:0] d);
    @(posedge i_mclk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_mclk);
    i_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(logic [3:0] a, logic [7:0] exp, string nm);
    @(posedge i_mclk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1 chk(nm, exp, o_rdata);
  endtask
  task automatic pulse(logic [3:0] p);
    @(posedge i_mclk);
    pul <= p;
    @(posedge i_mclk);
    pul <= 4'h0;
    #1;
  endtask
  task automatic wait_run();
    n_cyc = 0;
    while (o_cpu_run !== 1'b1 && n_cyc < 3000) begin
      @(posedge i_mclk);
      #1 n_cyc++;
    end
    if (n_cyc >= 3000) begin
      n_fail++;
      finish_test();
    end
  endtask
  ////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    {n_fail, num_checks, n_wdt, n_srv, n_full} = '0;
    {i_rd, i_wr, pul, i_addr, i_wdata, i_irq_req, i_stack_full, tick_on, i_rc_tick} = '0;
    {i_rst, i_cfg_wdt_en, i_cfg_rc_src, i_port_pins, i_irq_en} = {3'h7, 8'hFF, 4'hF};
    repeat (5) @(posedge i_mclk);
    i_rst <= 1'b0;
    rd(`ADDR_SELECT, `SELECT_RESET, "select reset");
    rd(`ADDR_FLAGS, 8'h00, "flags reset");
    wr(`ADDR_SELECT, 8'h7F);
    rd(`ADDR_SELECT, 8'hFF, "select rw");
    chk("pullup on", 8'h01, {7'h00, o_usb_pullup_en});
    wr(`ADDR_SELECT, 8'h00);
    chk("pullup off", 8'h00, {7'h00, o_usb_pullup_en});
    rd(4'h9, 8'h00, "unmapped");
    pulse(4'h1);
    chk("asleep", 8'h02, {5'h00, o_sys_clk_en, o_powerdown_flag, o_timeout_flag});
    i_port_pins <= 8'hFB;
    wait_run();
    chk("pin delay", 8'h01, {7'h00, n_cyc >= 1024 && n_cyc <= 1027});
    rd(`ADDR_FLAGS, 8'h06, "pin wake flags");
    i_port_pins <= 8'hFF;
    i_cfg_wdt_en <= 1'b0;
    pulse(4'h2);
    chk("clear no-op", 8'h01, {7'h00, o_powerdown_flag});
    i_cfg_wdt_en <= 1'b1;
    pulse(4'h2);
    chk("clear pd", 8'h00, {7'h00, o_powerdown_flag});
    i_irq_req <= 4'h1;
    pulse(4'h1);
    repeat (50) @(posedge i_mclk);
    #1 chk("blocked irq", 8'h00, {7'h00, o_cpu_run});
    {i_irq_req, i_irq_en} <= 8'h30;
    wait_run();
    rd(`ADDR_FLAGS, 8'h06, "disabled irq");
    chk("no service", 8'h00, n_srv[7:0]);
    {i_irq_req, i_irq_en} <= 8'h0F;
    pulse(4'h1);
    i_irq_req <= 4'h2;
    wait_run();
    @(posedge i_mclk);
    #1 chk("irq delay", 8'h01, {7'h00, n_cyc >= 1025 && n_srv == 1});
    rd(`ADDR_FLAGS, 8'h0A, "irq wake flags");
    i_irq_req <= 4'h0;
    tick_on <= 1'b1;
    pulse(4'h1);
    wait_run();
    tick_on <= 1'b0;
    @(posedge i_mclk);
    #1 chk("wdt wake", 8'h01, n_wdt[7:0]);
    rd(`ADDR_FLAGS, 8'h0F, "wdt flags");
    rd(`ADDR_IRQ_STATUS, 8'h03, "status");
    wr(`ADDR_IRQ_MASK, 8'h01);
    chk("irq on", 8'h01, {7'h00, o_irq});
    wr(`ADDR_IRQ_MASK, 8'h00);
    chk("irq masked", 8'h00, {7'h00, o_irq});
    wr(`ADDR_IRQ_MASK, 8'h01);
    wr(`ADDR_IRQ_STATUS, 8'h03);
    chk("irq cleared", 8'h00, {7'h00, o_irq});
    pulse(4'h4);
    chk("power-up pd", 8'h00, {7'h00, o_powerdown_flag});
    i_cfg_rc_src <= 1'b0;
    pulse(4'h1);
    repeat (1200) @(posedge i_mclk);
    #1 chk("instr stop", 8'h00, {7'h00, o_cpu_run});
    i_port_pins <= 8'hFE;
    wait_run();
    repeat (1100) @(posedge i_mclk);
    #1 chk("instr timeout", 8'h01, {7'h00, o_timeout_flag});
    pulse(4'h8);
    @(posedge i_mclk);
    #1 chk("full reset", 8'h01, n_full[7:0]);
    finish_test();
  end
endmodule
